// file: verilog/tcc_consts.svh
// Offsets, bit positions, reset values and timing counts of the timer block.
// Included by the timer module; definitions only.
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// Register offsets
`define TCC_A_CTRL      8'h12
`define TCC_A_STAT      8'h13
`define TCC_A_CAP1_HI   8'h14
`define TCC_A_CAP1_LO   8'h15
`define TCC_A_CMP1_HI   8'h16
`define TCC_A_CMP1_LO   8'h17
`define TCC_A_CNT_HI    8'h18
`define TCC_A_CNT_LO    8'h19
`define TCC_A_ALT_HI    8'h1a
`define TCC_A_ALT_LO    8'h1b
`define TCC_A_CAP2_HI   8'h1c
`define TCC_A_CAP2_LO   8'h1d
`define TCC_A_CMP2_HI   8'h1e
`define TCC_A_CMP2_LO   8'h1f

// Control bits
`define TCC_C_CAP_IE    7
`define TCC_C_CMP_IE    6
`define TCC_C_OVF_IE    5
`define TCC_C_FORCE2    4
`define TCC_C_FORCE1    3
`define TCC_C_LEVEL2    2
`define TCC_C_EDGE1     1
`define TCC_C_LEVEL1    0

// Status bits
`define TCC_S_CAP1      7
`define TCC_S_CMP1      6
`define TCC_S_OVF       5
`define TCC_S_CAP2      4
`define TCC_S_CMP2      3

// Reset values and timing
`define TCC_CTRL_RESET  8'h00
`define TCC_CNT_RESET   16'hfffc
`define TCC_PRESCALE    2'h3
`endif

// file: verilog/tcc_pkg.sv
// Types shared by the timer control, status and capture block.
// Constants live in tcc_consts.svh.
package tcc_pkg;
	typedef logic [7:0] tcc_byte_t;
	typedef logic [15:0] tcc_word_t;
	typedef logic [1:0] tcc_pair_t;
endpackage

// file: verilog/tcc_timer.sv
// Timer control, status flags, free-running counter, two captures and two compares.
// Assumes a single-cycle register port and pins synchronous to CLK.
//
// How it works
// - Control holds capture/compare/overflow enables, levels and edge select; force bits are not stored.
// - Interrupt requested while any flag is set with its group enable.
// - Force bits read zero; writing one copies level bit to the pin latch.
// - A forced compare leaves the compare flag untouched.
// - A real compare match loads the pin latch from its level bit.
// - Capture 1 takes rising edges when edge select is one, else falling.
// - Capture 2 takes falling edges only.
// - Status holds capture1, compare1, overflow, capture2, compare2 in bits 7 to 3.
// - A flag clears only after a status access then its own register access.
// - Capture flags clear on status read then capture low byte read.
// - Compare flags clear on status read then compare low byte access.
// - Overflow sets on wrap; clears on status access then counter low read.
// - Compare flag sets when compare register equals the counter.
// - Every valid edge loads the capture register from the counter and sets the flag, except while a capture high byte read is blocking.
// - Captured value is one above the counter before the edge.
// - Capture high byte read blocks transfers until low byte read.
// - Reading the capture low byte never blocks a transfer.
// - Capture 1 is read-only, high byte then low byte.
// - Capture 2 is read-only, high byte then low byte.
// - Reset leaves both capture registers unchanged.
// - Capture resolution is one count, four clock cycles.
// - Counter resets to fffc and advances through a divide-by-four prescaler.
// - Alternate counter low read never clears overflow.
//
// Design decision made here: strobed register access.
`include "tcc_consts.svh"

module tcc_timer (
	// Clock and reset
	input  wire logic             CLK,
	input  wire logic             RESET,
	// Register port
	input  wire logic [7:0]       ADDR,
	input  wire logic [7:0]       WDATA,
	input  wire logic             WR,
	input  wire logic             RD,
	output tcc_pkg::tcc_byte_t    RDATA,
	// Pins
	input  wire logic             CAPTURE1_PIN,
	input  wire logic             CAPTURE2_PIN,
	output logic                  COMPARE1_PIN,
	output logic                  COMPARE2_PIN,
	// Interrupt request
	output logic                  TIMER_IRQ
);

	// Control and status state
	tcc_pkg::tcc_byte_t ctrl_q;
	tcc_pkg::tcc_byte_t ctrl_d;
	tcc_pkg::tcc_pair_t cap_flag_q;
	tcc_pkg::tcc_pair_t cap_flag_d;
	tcc_pkg::tcc_pair_t cmp_flag_q;
	tcc_pkg::tcc_pair_t cmp_flag_d;
	logic               ovf_flag_q;
	logic               ovf_flag_d;
	tcc_pkg::tcc_pair_t cap_arm_q;
	tcc_pkg::tcc_pair_t cap_arm_d;
	tcc_pkg::tcc_pair_t cmp_arm_q;
	tcc_pkg::tcc_pair_t cmp_arm_d;
	logic               ovf_arm_q;
	logic               ovf_arm_d;

	// Counter state
	tcc_pkg::tcc_word_t cnt_q;
	tcc_pkg::tcc_word_t cnt_d;
	logic [1:0]         presc_q;
	logic [1:0]         presc_d;
	tcc_pkg::tcc_byte_t cnt_buf_q;
	logic               cnt_seq_q;
	logic               cnt_seq_d;

	// Capture and compare storage
	tcc_pkg::tcc_word_t cap_val_q [2];
	tcc_pkg::tcc_word_t cmp_val_q [2];
	tcc_pkg::tcc_pair_t cap_block_q;
	tcc_pkg::tcc_pair_t cap_block_d;
	tcc_pkg::tcc_pair_t cmp_inhib_q;
	tcc_pkg::tcc_pair_t cmp_inhib_d;
	tcc_pkg::tcc_pair_t pin_q;
	tcc_pkg::tcc_pair_t pin_prev_q;
	tcc_pkg::tcc_pair_t level_q;
	tcc_pkg::tcc_pair_t level_d;

	// Output registers
	tcc_pkg::tcc_byte_t rdata_q;
	tcc_pkg::tcc_byte_t rdata_d;
	logic               irq_q;
	logic               irq_d;

	// Address decode
	wire logic sel_ctrl    = (ADDR == `TCC_A_CTRL);
	wire logic sel_stat    = (ADDR == `TCC_A_STAT);
	wire logic sel_cap1_hi = (ADDR == `TCC_A_CAP1_HI);
	wire logic sel_cap1_lo = (ADDR == `TCC_A_CAP1_LO);
	wire logic sel_cmp1_hi = (ADDR == `TCC_A_CMP1_HI);
	wire logic sel_cmp1_lo = (ADDR == `TCC_A_CMP1_LO);
	wire logic sel_cnt_hi  = (ADDR == `TCC_A_CNT_HI);
	wire logic sel_cnt_lo  = (ADDR == `TCC_A_CNT_LO);
	wire logic sel_alt_hi  = (ADDR == `TCC_A_ALT_HI);
	wire logic sel_alt_lo  = (ADDR == `TCC_A_ALT_LO);
	wire logic sel_cap2_hi = (ADDR == `TCC_A_CAP2_HI);
	wire logic sel_cap2_lo = (ADDR == `TCC_A_CAP2_LO);
	wire logic sel_cmp2_hi = (ADDR == `TCC_A_CMP2_HI);
	wire logic sel_cmp2_lo = (ADDR == `TCC_A_CMP2_LO);

	wire logic wr_ctrl      = WR && sel_ctrl;
	wire logic stat_access  = (WR || RD) && sel_stat;
	wire logic stat_read    = RD && sel_stat;
	wire logic any_cnt_hi_rd = RD && (sel_cnt_hi || sel_alt_hi);
	wire logic any_cnt_lo_rd = RD && (sel_cnt_lo || sel_alt_lo);
	wire logic any_cnt_lo_wr = WR && (sel_cnt_lo || sel_alt_lo);
	// Only the primary low byte finishes the overflow clear
	wire logic ovf_clear_rd = RD && sel_cnt_lo;

	wire tcc_pkg::tcc_pair_t cap_hi_rd = {RD && sel_cap2_hi, RD && sel_cap1_hi};
	wire tcc_pkg::tcc_pair_t cap_lo_rd = {RD && sel_cap2_lo, RD && sel_cap1_lo};
	wire tcc_pkg::tcc_pair_t cmp_hi_wr = {WR && sel_cmp2_hi, WR && sel_cmp1_hi};
	wire tcc_pkg::tcc_pair_t cmp_lo_wr = {WR && sel_cmp2_lo, WR && sel_cmp1_lo};
	wire tcc_pkg::tcc_pair_t cmp_lo_acc = {(WR || RD) && sel_cmp2_lo,
		(WR || RD) && sel_cmp1_lo};

	// Control fields
	wire logic cap_ie  = ctrl_q[`TCC_C_CAP_IE];
	wire logic cmp_ie  = ctrl_q[`TCC_C_CMP_IE];
	wire logic ovf_ie  = ctrl_q[`TCC_C_OVF_IE];
	wire logic edge1   = ctrl_q[`TCC_C_EDGE1];
	wire tcc_pkg::tcc_pair_t lvl_bits = {ctrl_q[`TCC_C_LEVEL2], ctrl_q[`TCC_C_LEVEL1]};
	// Forcing uses the value written in the same cycle, so one write changes and forces
	wire tcc_pkg::tcc_pair_t force_wr = {wr_ctrl && WDATA[`TCC_C_FORCE2],
		wr_ctrl && WDATA[`TCC_C_FORCE1]};
	wire tcc_pkg::tcc_pair_t force_lvl = {WDATA[`TCC_C_LEVEL2], WDATA[`TCC_C_LEVEL1]};

	// Counter advance; tick marks the cycle after the counter changed
	wire logic presc_end  = (presc_q == `TCC_PRESCALE);
	wire logic cnt_tick   = (presc_q == 2'h0);
	wire logic cnt_wrap   = presc_end && (cnt_q == 16'hffff);
	wire tcc_pkg::tcc_word_t cnt_plus1 = cnt_q + 16'h0001;

	// Per-channel capture and compare events
	tcc_pkg::tcc_pair_t cap_edge;
	tcc_pkg::tcc_pair_t cap_load;
	tcc_pkg::tcc_pair_t cmp_match;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			wire logic rise = pin_q[ch] && !pin_prev_q[ch];
			wire logic fall = !pin_q[ch] && pin_prev_q[ch];
			if (ch == 0)
			begin : g_sel
				assign cap_edge[ch] = edge1 ? rise : fall;
			end
			else
			begin : g_fall
				assign cap_edge[ch] = fall;
			end
			// A low-byte read in the same cycle does not hold off the transfer
			assign cap_load[ch] = cap_edge[ch] && !cap_block_q[ch];
			assign cmp_match[ch] = cnt_tick && !cmp_inhib_q[ch]
				&& (cmp_val_q[ch] == cnt_q);

			always_ff @(posedge CLK)
			begin
				// No reset term: contents survive reset
				if (cap_load[ch])
					cap_val_q[ch] <= cnt_plus1;
			end

			always_ff @(posedge CLK)
			begin
				if (cmp_hi_wr[ch])
					cmp_val_q[ch][15:8] <= WDATA;
				if (cmp_lo_wr[ch])
					cmp_val_q[ch][7:0] <= WDATA;
			end
		end
	endgenerate

	// Flag, arm and blocking next state
	always_comb
	begin
		cap_flag_d  = cap_flag_q;
		cmp_flag_d  = cmp_flag_q;
		ovf_flag_d  = ovf_flag_q;
		cap_arm_d   = cap_arm_q;
		cmp_arm_d   = cmp_arm_q;
		ovf_arm_d   = ovf_arm_q;
		cap_block_d = cap_block_q;
		cmp_inhib_d = cmp_inhib_q;
		level_d     = level_q;
		for (int i = 0; i < 2; i++)
		begin
			// Arm on a status read that sees the flag set
			if (stat_read && cap_flag_q[i])
				cap_arm_d[i] = 1'b1;
			if (stat_read && cmp_flag_q[i])
				cmp_arm_d[i] = 1'b1;
			if (cap_lo_rd[i] && cap_arm_q[i])
			begin
				cap_flag_d[i] = 1'b0;
				cap_arm_d[i]  = 1'b0;
			end
			if (cmp_lo_acc[i] && cmp_arm_q[i])
			begin
				cmp_flag_d[i] = 1'b0;
				cmp_arm_d[i]  = 1'b0;
			end
			// Set beats clear when both land in one cycle
			if (cap_load[i])
				cap_flag_d[i] = 1'b1;
			if (cmp_match[i])
				cmp_flag_d[i] = 1'b1;
			// Capture block
			if (cap_hi_rd[i])
				cap_block_d[i] = 1'b1;
			if (cap_lo_rd[i])
				cap_block_d[i] = 1'b0;
			// Compare inhibit between high and low byte writes
			if (cmp_hi_wr[i])
				cmp_inhib_d[i] = 1'b1;
			if (cmp_lo_wr[i])
				cmp_inhib_d[i] = 1'b0;
			// Output level latch; force does not touch the flag
			if (cmp_match[i])
				level_d[i] = lvl_bits[i];
			if (force_wr[i])
				level_d[i] = force_lvl[i];
		end
		// Overflow arms on any status access
		if (stat_access && ovf_flag_q)
			ovf_arm_d = 1'b1;
		if (ovf_clear_rd && ovf_arm_q)
		begin
			ovf_flag_d = 1'b0;
			ovf_arm_d  = 1'b0;
		end
		if (cnt_wrap)
			ovf_flag_d = 1'b1;
	end

	// Counter, prescaler and low-byte buffer next state
	always_comb
	begin
		cnt_d     = cnt_q;
		presc_d   = presc_q + 2'h1;
		cnt_seq_d = cnt_seq_q;
		if (presc_end)
			cnt_d = cnt_plus1;
		if (any_cnt_hi_rd)
			cnt_seq_d = 1'b1;
		if (any_cnt_lo_rd)
			cnt_seq_d = 1'b0;
		// Writing either low byte restarts the counter and ends a pending read
		if (any_cnt_lo_wr)
		begin
			cnt_d     = `TCC_CNT_RESET;
			presc_d   = 2'h0;
			cnt_seq_d = 1'b0;
		end
	end

	// Control register next state; force bits are never stored
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (wr_ctrl)
		begin
			ctrl_d = WDATA;
			ctrl_d[`TCC_C_FORCE2] = 1'b0;
			ctrl_d[`TCC_C_FORCE1] = 1'b0;
		end
	end

	// Read data mux; unmapped addresses read zero
	always_comb
	begin
		rdata_d = 8'h00;
		if (RD)
		begin
			if (sel_ctrl)
				rdata_d = ctrl_q;
			else if (sel_stat)
				rdata_d = {cap_flag_q[0], cmp_flag_q[0], ovf_flag_q,
					cap_flag_q[1], cmp_flag_q[1], 3'h0};
			else if (sel_cap1_hi)
				rdata_d = cap_val_q[0][15:8];
			else if (sel_cap1_lo)
				rdata_d = cap_val_q[0][7:0];
			else if (sel_cap2_hi)
				rdata_d = cap_val_q[1][15:8];
			else if (sel_cap2_lo)
				rdata_d = cap_val_q[1][7:0];
			else if (sel_cmp1_hi)
				rdata_d = cmp_val_q[0][15:8];
			else if (sel_cmp1_lo)
				rdata_d = cmp_val_q[0][7:0];
			else if (sel_cmp2_hi)
				rdata_d = cmp_val_q[1][15:8];
			else if (sel_cmp2_lo)
				rdata_d = cmp_val_q[1][7:0];
			else if (sel_cnt_hi || sel_alt_hi)
				rdata_d = cnt_q[15:8];
			else if (sel_cnt_lo || sel_alt_lo)
				rdata_d = cnt_seq_q ? cnt_buf_q : cnt_q[7:0];
		end
	end

	// Combined interrupt request
	assign irq_d = (|cap_flag_q && cap_ie)
		|| (|cmp_flag_q && cmp_ie)
		|| (ovf_flag_q && ovf_ie);

	// State registers
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			ctrl_q      <= `TCC_CTRL_RESET;
			cnt_q       <= `TCC_CNT_RESET;
			presc_q     <= 2'h0;
			cnt_seq_q   <= 1'b0;
			cap_flag_q  <= 2'h0;
			cmp_flag_q  <= 2'h0;
			ovf_flag_q  <= 1'b0;
			cap_arm_q   <= 2'h0;
			cmp_arm_q   <= 2'h0;
			ovf_arm_q   <= 1'b0;
			cap_block_q <= 2'h0;
			cmp_inhib_q <= 2'h0;
			level_q     <= 2'h0;
			rdata_q     <= 8'h00;
			irq_q       <= 1'b0;
		end
		else
		begin
			ctrl_q      <= ctrl_d;
			cnt_q       <= cnt_d;
			presc_q     <= presc_d;
			cnt_seq_q   <= cnt_seq_d;
			cap_flag_q  <= cap_flag_d;
			cmp_flag_q  <= cmp_flag_d;
			ovf_flag_q  <= ovf_flag_d;
			cap_arm_q   <= cap_arm_d;
			cmp_arm_q   <= cmp_arm_d;
			ovf_arm_q   <= ovf_arm_d;
			cap_block_q <= cap_block_d;
			cmp_inhib_q <= cmp_inhib_d;
			level_q     <= level_d;
			rdata_q     <= rdata_d;
			irq_q       <= irq_d;
		end
	end

	// Buffer holds the low byte seen by the first high-byte read
	always_ff @(posedge CLK)
	begin
		if (RESET)
			cnt_buf_q <= 8'h00;
		else if (any_cnt_hi_rd && !cnt_seq_q)
			cnt_buf_q <= cnt_q[7:0];
	end

	// Pin sampling for edge detection; pins arrive synchronous to CLK
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			pin_q      <= 2'h3;
			pin_prev_q <= 2'h3;
		end
		else
		begin
			pin_q      <= {CAPTURE2_PIN, CAPTURE1_PIN};
			pin_prev_q <= pin_q;
		end
	end

	assign RDATA        = rdata_q;
	assign COMPARE1_PIN = level_q[0];
	assign COMPARE2_PIN = level_q[1];
	assign TIMER_IRQ    = irq_q;

endmodule

// file: sim/tcc_pin_model.sv
// Outside world at the capture inputs of the timer block.
// Levels change just after a rising CLK edge; both inputs idle high.
module tcc_pin_model (
	// Clock
	input wire logic  CLK,
	// Capture inputs of the timer
	output logic      CAP1,
	output logic      CAP2
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		CAP1 = 1'b1;
		CAP2 = 1'b1;
	end
	// One level change per call, so every edge is seen by the timer
	task automatic drive(input int ch, input logic v);
		@(posedge CLK);
		if (ch == 1)
			CAP1 <= v;
		else
			CAP2 <= v;
	endtask
endmodule

// file: sim/tcc_timer_assertions.sv
// Assertions on the register port, compare pins and interrupt of the timer.
// Sees only the ports of tcc_timer; bound to it at the foot of this file.
module tcc_timer_checker (
	// Clock and reset
	input wire logic                CLK,
	input wire logic                RESET,
	// Register port
	input wire logic [7:0]          ADDR,
	input wire logic [7:0]          WDATA,
	input wire logic                WR,
	input wire logic                RD,
	input wire tcc_pkg::tcc_byte_t  RDATA,
	// Pins and interrupt
	input wire logic                CAPTURE1_PIN,
	input wire logic                CAPTURE2_PIN,
	input wire logic                COMPARE1_PIN,
	input wire logic                COMPARE2_PIN,
	input wire logic                TIMER_IRQ
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);
	sequence s_stat_rd;
		RD && ADDR == 8'h13;
	endsequence
	sequence s_ctrl_wr;
		WR && ADDR == 8'h12;
	endsequence
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data not zero outside a read");
	a_force_reads_zero: assert property ((RD && ADDR == 8'h12) |=> RDATA[4:3] == 2'h0)
		else $error("force bits read as one");
	a_status_unused: assert property (s_stat_rd |=> RDATA[2:0] == 3'h0)
		else $error("unused status bits not zero");
	a_ctrl_readback: assert property (s_ctrl_wr ##2 (RD && ADDR == 8'h12)
		|=> RDATA == ($past(WDATA, 3) & 8'he7))
		else $error("control read back differs");
	a_force_pin_one: assert property ((WR && ADDR == 8'h12 && WDATA[3])
		|=> ##1 COMPARE1_PIN == $past(WDATA[0], 2))
		else $error("forced level missing on compare pin 1");
	a_force_pin_two: assert property ((WR && ADDR == 8'h12 && WDATA[4])
		|=> ##1 COMPARE2_PIN == $past(WDATA[2], 2))
		else $error("forced level missing on compare pin 2");
	a_irq_no_flag: assert property (s_stat_rd ##1 (RDATA[7:3] == 5'h00) |-> !TIMER_IRQ)
		else $error("interrupt with no flag set");
	a_cap2_falls: assert property ($fell(CAPTURE2_PIN) ##3 s_stat_rd |=> RDATA[4])
		else $error("falling edge on capture 2 left flag clear");
endmodule

bind tcc_timer tcc_timer_checker chk (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .CAPTURE1_PIN(CAPTURE1_PIN),
	.CAPTURE2_PIN(CAPTURE2_PIN), .COMPARE1_PIN(COMPARE1_PIN),
	.COMPARE2_PIN(COMPARE2_PIN), .TIMER_IRQ(TIMER_IRQ));

// file: sim/testbench.sv
// Self-checking bench for the timer control, status and capture block.
// Capture inputs come from tcc_pin_model; the checker is bound separately.
`include "tcc_consts.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                clk;
	logic                reset;
	logic [7:0]          addr;
	logic [7:0]          wdata;
	logic                wr_s;
	logic                rd_s;
	tcc_pkg::tcc_byte_t  rdata;
	tcc_pkg::tcc_byte_t  hi;
	tcc_pkg::tcc_byte_t  lo;
	logic                cap1;
	logic                cap2;
	logic                cmp1;
	logic                cmp2;
	logic                irq;
	int                  n_errors;
	int                  num_checks;
	tcc_timer uut (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
		.RD(rd_s), .RDATA(rdata), .CAPTURE1_PIN(cap1), .CAPTURE2_PIN(cap2),
		.COMPARE1_PIN(cmp1), .COMPARE2_PIN(cmp2), .TIMER_IRQ(irq));
	tcc_pin_model pins (.CLK(clk), .CAP1(cap1), .CAP2(cap2));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic wr(input tcc_pkg::tcc_byte_t a, input tcc_pkg::tcc_byte_t v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	// Read data stand one cycle only, so they are taken just after the edge
	task automatic rd(input tcc_pkg::tcc_byte_t a, output tcc_pkg::tcc_byte_t v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic chk(input tcc_pkg::tcc_byte_t got, input tcc_pkg::tcc_byte_t exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input tcc_pkg::tcc_byte_t a, input tcc_pkg::tcc_byte_t m,
		input tcc_pkg::tcc_byte_t exp);
		tcc_pkg::tcc_byte_t v;
		rd(a, v);
		chk(v & m, exp);
	endtask
	task automatic report_and_stop();
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (3000) @(posedge clk);
		n_errors++;
		report_and_stop();
	end
	initial
	begin
		reset = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr_s = 1'b0;
		rd_s = 1'b0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		// Compare values are unknown after power-up; park them far ahead
		wr(`TCC_A_CMP1_HI, 8'h80);
		wr(`TCC_A_CMP2_HI, 8'h80);
		wr(`TCC_A_CMP1_LO, 8'h00);
		wr(`TCC_A_CMP2_LO, 8'h00);
		rchk(`TCC_A_CTRL, 8'hff, 8'h00);
		rchk(`TCC_A_STAT, 8'hff, 8'h00);
		rchk(8'h05, 8'hff, 8'h00);
		repeat (6) @(posedge clk);
		rchk(`TCC_A_STAT, 8'hff, 8'h20);
		wr(`TCC_A_CTRL, 8'h20);
		@(posedge clk);
		#1 chk({7'h00, irq}, 8'h01);
		rchk(`TCC_A_ALT_LO, 8'hff, 8'h02);
		rchk(`TCC_A_STAT, 8'hff, 8'h20);
		rchk(`TCC_A_CNT_LO, 8'hff, 8'h03);
		rchk(`TCC_A_STAT, 8'hff, 8'h00);
		chk({7'h00, irq}, 8'h00);
		wr(`TCC_A_CTRL, 8'hff);
		rchk(`TCC_A_CTRL, 8'hff, 8'he7);
		chk({6'h00, cmp2, cmp1}, 8'h03);
		rchk(`TCC_A_STAT, 8'hff, 8'h00);
		chk({7'h00, irq}, 8'h00);
		wr(`TCC_A_CTRL, 8'h18);
		rchk(`TCC_A_CTRL, 8'hff, 8'h00);
		chk({6'h00, cmp2, cmp1}, 8'h00);
		// Counter restart makes an overflow, so that flag is masked below
		for (int i = 0; i < 2; i++)
		begin
			hi = i ? `TCC_A_CMP2_HI : `TCC_A_CMP1_HI;
			lo = i ? `TCC_A_CMP2_LO : `TCC_A_CMP1_LO;
			wr(hi, 8'h00);
			wr(lo, 8'h06);
			wr(`TCC_A_CTRL, i ? 8'h44 : 8'h41);
			wr(`TCC_A_CNT_LO, 8'h00);
			repeat (48) @(posedge clk);
			chk({6'h00, cmp2, cmp1}, i ? 8'h03 : 8'h01);
			chk({7'h00, irq}, 8'h01);
			wr(lo, 8'h06);
			rchk(`TCC_A_STAT, 8'hdf, i ? 8'h08 : 8'h40);
			wr(lo, 8'h06);
			rchk(`TCC_A_STAT, 8'hdf, 8'h00);
			chk({7'h00, irq}, 8'h00);
			wr(hi, 8'h80);
			wr(lo, 8'h00);
		end
		wr(`TCC_A_CTRL, 8'h82);
		wr(`TCC_A_CNT_LO, 8'h00);
		repeat (3) @(posedge clk);
		pins.drive(1, 1'b0);
		repeat (3) @(posedge clk);
		#1 chk({7'h00, irq}, 8'h00);
		pins.drive(1, 1'b1);
		repeat (3) @(posedge clk);
		pins.drive(2, 1'b0);
		repeat (2) @(posedge clk);
		rchk(`TCC_A_STAT, 8'h90, 8'h90);
		chk({7'h00, irq}, 8'h01);
		rchk(`TCC_A_CAP1_HI, 8'hff, 8'hff);
		rchk(`TCC_A_CAP1_LO, 8'hff, 8'hff);
		rchk(`TCC_A_CAP2_HI, 8'hff, 8'h00);
		rchk(`TCC_A_CAP2_LO, 8'hff, 8'h00);
		rchk(`TCC_A_STAT, 8'h90, 8'h00);
		chk({7'h00, irq}, 8'h00);
		pins.drive(2, 1'b1);
		rchk(`TCC_A_CAP1_HI, 8'hff, 8'hff);
		pins.drive(1, 1'b0);
		pins.drive(1, 1'b1);
		repeat (3) @(posedge clk);
		rchk(`TCC_A_CAP1_LO, 8'hff, 8'hff);
		// Capture 2 saw only a rising edge since its flag was cleared
		rchk(`TCC_A_STAT, 8'h10, 8'h00);
		wr(`TCC_A_CAP1_LO, 8'h00);
		rchk(`TCC_A_CAP1_LO, 8'hff, 8'hff);
		@(posedge clk);
		reset <= 1'b1;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rchk(`TCC_A_CAP2_LO, 8'hff, 8'h00);
		rchk(`TCC_A_CAP1_LO, 8'hff, 8'hff);
		rchk(`TCC_A_CTRL, 8'hff, 8'h00);
		chk({6'h00, cmp2, cmp1}, 8'h00);
		// Edge select is clear after reset; the low-byte read lands in the load cycle
		pins.drive(1, 1'b0);
		rchk(`TCC_A_CAP1_LO, 8'hff, 8'hff);
		rchk(`TCC_A_STAT, 8'h90, 8'h80);
		rchk(`TCC_A_CAP1_HI, 8'hff, 8'hff);
		// Counter wraps four counts after reset; a status write arms the clear
		repeat (4) @(posedge clk);
		wr(`TCC_A_STAT, 8'h00);
		rchk(`TCC_A_CNT_LO, 8'hff, 8'h01);
		rchk(`TCC_A_STAT, 8'h20, 8'h00);
		report_and_stop();
	end
endmodule
